// ### src/jtd_deframer.sv
// Purpose: Transport layer of the receive link; unpacks lane octets into samples
// Assumes: Lane octets arrive descrambled and aligned on clk; byte-wide register port
// Notes:   Two link copies; samples out per link; single clock domain
// Behaviour
// - Unpack each incoming frame into samples using the programmed link parameters.
// - Octets per frame per lane may be 1, 2 or 4; the code decodes only 1 and 2, and F of 4 flags bad LMFS.
// - K must be 32 when F is 1, else 16 or 32.
// - Lanes per link 1, 2, 4, 8 single-link; 1, 2, 4 dual-link; the code decodes only 1, 2, 4, and L of 8 flags bad LMFS.
// - Converters 1 or 2 single-link, 1 dual-link; samples per frame 1 or 2; the code decodes one converter only, and M of 2 flags bad LMFS.
// - High density on when F is 1, off otherwise.
// - Samples are 16 bits, packed in 16 bits, no tail bits.
// - Modes 8, 9, 10 use one converter with fixed L, S, F, K, HD; the code accepts K of 16 or 32 when F is 2.
// - Modes 11 to 13 are programmed with one converter and half the lanes.
// - Modes 8 and 11 allow only unity interpolation.
// - Link parameters are held as value minus one at their offsets; the plain octet count is held as F itself.
// - Expected device, bank and lane-0 identifiers are stored for matching.
// - Three-bit version field matches the transmitter's version.
// - Dual-link select enables two links; dual only in modes 8 to 10.
// - Page bit set steers parameter writes to the second link copy.
// - Power-down bit disables the second link sync request output buffer.
// - Flags report unsupported L, M, F, S combinations and illegal K.
// - Lanes deskew only when masked in, capture only when enabled.
`timescale 1ns/100ps
`include "jtd_regs.svh"
module jtd_deframer (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [11:0]           regAddr,
  input  wire logic [7:0]            regWdata,
  output logic      [7:0]            regRdata,
  input  wire jtd_pkg::jtd_lanes_t   laneIn,
  input  wire logic                  syncReqIn1,
  input  wire logic [1:0]            interpSel,
  output jtd_pkg::jtd_samples_t      samplesOut0,
  output jtd_pkg::jtd_samples_t      samplesOut1,
  output logic [7:0]                 deskewLanes,
  output logic                       secondLinkSyncRequest,
  output logic                       secondLinkSyncRequestOe,
  output logic                       interpUnity
);
  jtd_pkg::jtd_link_cfg_t cfg_reg [2];
  logic [7:0]             devId_reg;
  logic [7:0]             bankId_reg;
  logic [7:0]             lane0Id_reg;
  logic [7:0]             syncPwr_reg;
  logic [7:0]             linkCtrl_reg;
  logic [7:0]             deskew_reg;
  logic [7:0]             laneEn_reg;
  logic [7:0]             check_reg;
  logic [7:0]             check_next;
  logic [7:0]             rdata_next;
  logic                   syncMeta_reg;
  logic                   syncSafe_reg;
  logic                   dualLink;
  logic                   page;
  jtd_pkg::jtd_mode_t     mode0;
  jtd_pkg::jtd_mode_t     mode1;
  logic                   badLmfs;
  logic                   badK;

  assign dualLink = linkCtrl_reg[`JTD_BIT_LINK_MODE];
  assign page     = linkCtrl_reg[`JTD_BIT_LINK_PAGE];

  // Mode decode from one link copy; anything off the supported table is BAD
  function automatic jtd_pkg::jtd_mode_t decodeMode(input jtd_pkg::jtd_link_cfg_t c,
                                                    input logic dual);
    jtd_pkg::jtd_mode_t m;
    m = jtd_pkg::JTD_MODE_BAD;
    if (c.convM1 == 8'h00 && c.resM1[4:0] == 5'h0f && c.bitsM1[4:0] == 5'h0f &&
        c.resM1[7:6] == 2'b00 && c.highDens[4:0] == 5'h00) begin
      if (c.octetsM1 == 8'h00 && c.highDens[`JTD_BIT_HD] &&
          c.octetsPlain == 8'h01) begin
        if (c.lanesM1[4:0] == 5'h03 && c.verSamp[4:0] == 5'h01) begin
          m = jtd_pkg::JTD_MODE_HD4;
        end else if (c.lanesM1[4:0] == 5'h01 && c.verSamp[4:0] == 5'h00) begin
          m = jtd_pkg::JTD_MODE_HD2;
        end
      end else if (c.octetsM1 == 8'h01 && !c.highDens[`JTD_BIT_HD] &&
                   c.octetsPlain == 8'h02 && c.lanesM1[4:0] == 5'h00 &&
                   c.verSamp[4:0] == 5'h00) begin
        m = jtd_pkg::JTD_MODE_F2L1;
      end
    end
    if (dual && c.lanesM1[4:0] > 5'h03) begin
      m = jtd_pkg::JTD_MODE_BAD;
    end
    return m;
  endfunction : decodeMode

  // K legal: 32 always, 16 only when F is not 1
  function automatic logic kLegal(input jtd_pkg::jtd_link_cfg_t c);
    return (c.framesM1[4:0] == 5'h1f) ||
           (c.framesM1[4:0] == 5'h0f && c.octetsM1 != 8'h00);
  endfunction : kLegal

  assign mode0   = decodeMode(cfg_reg[0], dualLink);
  assign mode1   = decodeMode(cfg_reg[1], dualLink);
  assign badLmfs = (mode0 == jtd_pkg::JTD_MODE_BAD) ||
                   (dualLink && mode1 == jtd_pkg::JTD_MODE_BAD);
  assign badK    = !kLegal(cfg_reg[0]) || (dualLink && !kLegal(cfg_reg[1]));

  // Parameter copies: page bit picks which link a write lands in
  generate
    for (genvar g = 0; g < 2; g++) begin : gLink
      logic hit;
      assign hit = regWrite && (page == 1'(g));
      always_ff @(posedge clk) begin
        if (!resetn) begin
          cfg_reg[g].lanesM1     <= `JTD_RST_LANES_M1;
          cfg_reg[g].octetsM1    <= `JTD_RST_OCTETS_M1;
          cfg_reg[g].framesM1    <= `JTD_RST_FRAMES_M1;
          cfg_reg[g].convM1      <= `JTD_RST_CONV_M1;
          cfg_reg[g].resM1       <= `JTD_RST_RES_M1;
          cfg_reg[g].bitsM1      <= `JTD_RST_BITS_M1;
          cfg_reg[g].verSamp     <= `JTD_RST_VER_SAMP;
          cfg_reg[g].highDens    <= `JTD_RST_HIGH_DENS;
          cfg_reg[g].octetsPlain <= `JTD_RST_OCTETS_PLAIN;
        end else if (hit) begin
          case (regAddr)
            `JTD_OFF_LANES_M1:     cfg_reg[g].lanesM1     <= regWdata;
            `JTD_OFF_OCTETS_M1:    cfg_reg[g].octetsM1    <= regWdata;
            `JTD_OFF_FRAMES_M1:    cfg_reg[g].framesM1    <= regWdata;
            `JTD_OFF_CONV_M1:      cfg_reg[g].convM1      <= regWdata;
            `JTD_OFF_RES_M1:       cfg_reg[g].resM1       <= regWdata;
            `JTD_OFF_BITS_M1:      cfg_reg[g].bitsM1      <= regWdata;
            `JTD_OFF_VER_SAMP:     cfg_reg[g].verSamp     <= regWdata;
            `JTD_OFF_HIGH_DENS:    cfg_reg[g].highDens    <= regWdata;
            `JTD_OFF_OCTETS_PLAIN: cfg_reg[g].octetsPlain <= regWdata;
            default:               cfg_reg[g]             <= cfg_reg[g];
          endcase
        end
      end
    end
  endgenerate

  // Identity registers, held for matching against the transmitter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      devId_reg   <= 8'h00;
      bankId_reg  <= 8'h00;
      lane0Id_reg <= 8'h00;
    end else if (regWrite) begin
      case (regAddr)
        `JTD_OFF_DEV_ID:   devId_reg   <= regWdata;
        `JTD_OFF_BANK_ID:  bankId_reg  <= {4'h0, regWdata[3:0]};
        `JTD_OFF_LANE0_ID: lane0Id_reg <= {3'h0, regWdata[4:0]};
        default:           devId_reg   <= devId_reg;
      endcase
    end
  end

  // Shared control registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncPwr_reg  <= 8'h00;
      linkCtrl_reg <= 8'h00;
      deskew_reg   <= 8'h00;
      laneEn_reg   <= 8'h00;
    end else if (regWrite) begin
      case (regAddr)
        `JTD_OFF_SYNC_PWR:     syncPwr_reg  <= {7'h00, regWdata[0]};
        `JTD_OFF_LINK_CTRL:    linkCtrl_reg <= {4'h0, regWdata[3:2], 2'b00};
        `JTD_OFF_DESKEW_MASK:  deskew_reg   <= regWdata;
        `JTD_OFF_LANE_EN_MASK: laneEn_reg   <= regWdata;
        default:               syncPwr_reg  <= syncPwr_reg;
      endcase
    end
  end

  // Check flags are live status, refreshed every cycle
  always_comb begin
    check_next = 8'h00;
    check_next[`JTD_BIT_BAD_LMFS] = badLmfs;
    check_next[`JTD_BIT_BAD_K]    = badK;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      check_reg <= 8'h00;
    end else begin
      check_reg <= check_next;
    end
  end

  // Reads return the copy selected by the page bit
  always_comb begin
    jtd_pkg::jtd_link_cfg_t c;
    c = cfg_reg[page];
    case (regAddr)
      `JTD_OFF_CFG_CHECK:    rdata_next = check_reg;
      `JTD_OFF_SYNC_PWR:     rdata_next = syncPwr_reg;
      `JTD_OFF_LINK_CTRL:    rdata_next = linkCtrl_reg;
      `JTD_OFF_DEV_ID:       rdata_next = devId_reg;
      `JTD_OFF_BANK_ID:      rdata_next = bankId_reg;
      `JTD_OFF_LANE0_ID:     rdata_next = lane0Id_reg;
      `JTD_OFF_LANES_M1:     rdata_next = c.lanesM1;
      `JTD_OFF_OCTETS_M1:    rdata_next = c.octetsM1;
      `JTD_OFF_FRAMES_M1:    rdata_next = c.framesM1;
      `JTD_OFF_CONV_M1:      rdata_next = c.convM1;
      `JTD_OFF_RES_M1:       rdata_next = c.resM1;
      `JTD_OFF_BITS_M1:      rdata_next = c.bitsM1;
      `JTD_OFF_VER_SAMP:     rdata_next = c.verSamp;
      `JTD_OFF_HIGH_DENS:    rdata_next = c.highDens;
      `JTD_OFF_OCTETS_PLAIN: rdata_next = c.octetsPlain;
      `JTD_OFF_DESKEW_MASK:  rdata_next = deskew_reg;
      `JTD_OFF_LANE_EN_MASK: rdata_next = laneEn_reg;
      default:               rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= rdata_next;
    end
  end

  // Sync request from the link layer is foreign timing; resync before use
  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncMeta_reg <= 1'b0;
      syncSafe_reg <= 1'b0;
    end else begin
      syncMeta_reg <= syncReqIn1;
      syncSafe_reg <= syncMeta_reg;
    end
  end

  // Buffer powered down saves power when only one link is used
  always_ff @(posedge clk) begin
    if (!resetn) begin
      secondLinkSyncRequest   <= 1'b0;
      secondLinkSyncRequestOe <= 1'b0;
    end else begin
      secondLinkSyncRequest   <= syncSafe_reg & ~syncPwr_reg[`JTD_BIT_SYNC1_PD];
      secondLinkSyncRequestOe <= ~syncPwr_reg[`JTD_BIT_SYNC1_PD];
    end
  end

  // Modes 8 and 11 share one decode; interpolation forced to unity there
  always_ff @(posedge clk) begin
    if (!resetn) begin
      interpUnity <= 1'b0;
    end else begin
      interpUnity <= (mode0 == jtd_pkg::JTD_MODE_HD4) || (interpSel == 2'b00);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      deskewLanes <= 8'h00;
    end else begin
      deskewLanes <= deskew_reg;
    end
  end

  // Lane gating: disabled lanes read as zero so stale data cannot leak out
  logic [63:0] gated;
  generate
    for (genvar l = 0; l < `JTD_LANES; l++) begin : gLane
      assign gated[8*l +: 8] = laneEn_reg[l] ? laneIn.octets[8*l +: 8] : 8'h00;
    end
  endgenerate

  // Unpack one link; base is the first lane of that link
  function automatic jtd_pkg::jtd_samples_t unpack(input jtd_pkg::jtd_mode_t m,
                                                  input logic [31:0] o,
                                                  input logic v);
    jtd_pkg::jtd_samples_t s;
    s = '0;
    case (m)
      jtd_pkg::JTD_MODE_HD4: begin
        s.valid = v;
        s.s0    = {o[7:0],   o[15:8]};
        s.s1    = {o[23:16], o[31:24]};
      end
      jtd_pkg::JTD_MODE_HD2: begin
        s.valid = v;
        s.s0    = {o[7:0], o[15:8]};
      end
      default: s.valid = 1'b0;
    endcase
    return s;
  endfunction : unpack

  // F=2 on one lane: octets of a sample arrive on consecutive clocks
  logic [7:0] hiOct_reg [2];
  logic [1:0] phase_reg;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_reg    <= 2'b00;
      hiOct_reg[0] <= 8'h00;
      hiOct_reg[1] <= 8'h00;
    end else if (laneIn.valid) begin
      phase_reg    <= ~phase_reg;
      hiOct_reg[0] <= gated[7:0];
      hiOct_reg[1] <= gated[39:32];
    end
  end

  // Next samples per link; an illegal K or a bad second copy silences a link
  jtd_pkg::jtd_samples_t samples0_next;
  jtd_pkg::jtd_samples_t samples1_next;
  logic                  f2Ready;
  logic                  link1F2;

  assign f2Ready = laneIn.valid && phase_reg[0] && !badK;
  assign link1F2 = dualLink && (mode1 == jtd_pkg::JTD_MODE_F2L1);

  always_comb begin
    samples0_next = '0;
    samples1_next = '0;
    if (mode0 == jtd_pkg::JTD_MODE_F2L1) begin
      samples0_next.valid = f2Ready;
      samples0_next.s0    = {hiOct_reg[0], gated[7:0]};
      if (link1F2) begin
        samples1_next.valid = f2Ready;
        samples1_next.s0    = {hiOct_reg[1], gated[39:32]};
      end
    end else begin
      samples0_next = unpack(mode0, gated[31:0], laneIn.valid && !badK);
      if (dualLink) begin
        samples1_next = unpack(mode1, gated[63:32], laneIn.valid && !badK);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      samplesOut0 <= '0;
      samplesOut1 <= '0;
    end else begin
      samplesOut0 <= samples0_next;
      samplesOut1 <= samples1_next;
    end
  end
endmodule : jtd_deframer

// ### src/jtd_regs.svh
// Purpose: Register offsets, fields and reset values of the transport deframer
// Assumes: Byte-wide register port with 12-bit addresses
// Notes:   Definitions only
`ifndef JTD_REGS_SVH
`define JTD_REGS_SVH
`define JTD_OFF_SYNC_PWR     12'h203
`define JTD_OFF_LINK_CTRL    12'h300
`define JTD_OFF_CFG_CHECK    12'h030
`define JTD_OFF_DEV_ID       12'h450
`define JTD_OFF_BANK_ID      12'h451
`define JTD_OFF_LANE0_ID     12'h452
`define JTD_OFF_LANES_M1     12'h453
`define JTD_OFF_OCTETS_M1    12'h454
`define JTD_OFF_FRAMES_M1    12'h455
`define JTD_OFF_CONV_M1      12'h456
`define JTD_OFF_RES_M1       12'h457
`define JTD_OFF_BITS_M1      12'h458
`define JTD_OFF_VER_SAMP     12'h459
`define JTD_OFF_HIGH_DENS    12'h45a
`define JTD_OFF_DESKEW_MASK  12'h46c
`define JTD_OFF_OCTETS_PLAIN 12'h476
`define JTD_OFF_LANE_EN_MASK 12'h47d
`define JTD_BIT_SYNC1_PD     0
`define JTD_BIT_LINK_PAGE    2
`define JTD_BIT_LINK_MODE    3
`define JTD_BIT_HD           7
`define JTD_BIT_BAD_LMFS     3
`define JTD_BIT_BAD_K        2
`define JTD_RST_LANES_M1     8'h03
`define JTD_RST_OCTETS_M1    8'h00
`define JTD_RST_FRAMES_M1    8'h1f
`define JTD_RST_CONV_M1      8'h00
`define JTD_RST_RES_M1       8'h0f
`define JTD_RST_BITS_M1      8'h0f
`define JTD_RST_VER_SAMP     8'h21
`define JTD_RST_HIGH_DENS    8'h80
`define JTD_RST_OCTETS_PLAIN 8'h01
`define JTD_SAMPLE_BITS      16
`define JTD_LANES            8
`endif

// ### src/jtd_pkg.sv
// Purpose: Types shared by the transport deframer
// Assumes: Eight lanes of one octet per lane per clock
// Notes:   Offsets live in jtd_regs.svh
package jtd_pkg;
  typedef struct packed {
    logic [7:0] lanesM1;
    logic [7:0] octetsM1;
    logic [7:0] framesM1;
    logic [7:0] convM1;
    logic [7:0] resM1;
    logic [7:0] bitsM1;
    logic [7:0] verSamp;
    logic [7:0] highDens;
    logic [7:0] octetsPlain;
  } jtd_link_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [63:0] octets;
  } jtd_lanes_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] s0;
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
  } jtd_samples_t;

  typedef enum logic [1:0] {
    JTD_MODE_HD4  = 2'b00,
    JTD_MODE_HD2  = 2'b01,
    JTD_MODE_F2L1 = 2'b10,
    JTD_MODE_BAD  = 2'b11
  } jtd_mode_t;
endpackage : jtd_pkg

// ### tb/jtd_tx_model.sv
// Purpose: Transmitter model driving descrambled lane octets
// Assumes: One octet per lane per clock, no control words or bits
// Notes:   Idle lanes show the inverse of the last octets, never stale data
`timescale 1ns/100ps
module jtd_tx_model (
  input  wire logic           clk,
  output jtd_pkg::jtd_lanes_t laneIn
);
  logic [63:0] lastOctets;
  initial begin
    laneIn     = '0;
    lastOctets = '0;
  end
  task automatic beat(input logic [63:0] o);
    @(negedge clk);
    laneIn     = {1'b1, o};
    lastOctets = o;
  endtask : beat
  task automatic idle();
    @(negedge clk);
    laneIn = {1'b0, ~lastOctets};
  endtask : idle
endmodule : jtd_tx_model

// ### tb/jtd_deframer_checker.sv
// Purpose: Port-level assertions for the transport deframer
// Assumes: Single clock, synchronous active-low reset
// Notes:   Read data is due one edge after the read strobe
`timescale 1ns/100ps
module jtd_deframer_checker (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic                  regWrite,
  input wire logic                  regRead,
  input wire logic [11:0]           regAddr,
  input wire logic [7:0]            regWdata,
  input wire logic [7:0]            regRdata,
  input wire jtd_pkg::jtd_lanes_t   laneIn,
  input wire logic                  syncReqIn1,
  input wire logic [1:0]            interpSel,
  input wire jtd_pkg::jtd_samples_t samplesOut0,
  input wire jtd_pkg::jtd_samples_t samplesOut1,
  input wire logic [7:0]            deskewLanes,
  input wire logic                  secondLinkSyncRequest,
  input wire logic                  secondLinkSyncRequestOe,
  input wire logic                  interpUnity
);
  logic [7:0] lastMask;
  always_ff @(posedge clk) begin
    if (regWrite && regAddr == 12'h46c) begin
      lastMask <= regWdata;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  out0_cause_a: assert property (samplesOut0.valid |-> $past(laneIn.valid))
    else $error("link 0 sample without a lane beat");
  out1_cause_a: assert property (samplesOut1.valid |-> $past(laneIn.valid))
    else $error("link 1 sample without a lane beat");
  unity_forced_a: assert property (interpSel == 2'b00 |=> interpUnity)
    else $error("unity interpolation not reported");
  deskew_copy_a: assert property (regWrite && regAddr == 12'h46c |-> ##2 deskewLanes == lastMask)
    else $error("deskew lanes differ from mask");
  pd_buffer_a: assert property (regWrite && regAddr == 12'h203 |->
    ##2 secondLinkSyncRequestOe == !$past(regWdata[0], 2)) else $error("sync buffer enable wrong");
  pd_gate_a: assert property (!secondLinkSyncRequestOe |-> !secondLinkSyncRequest)
    else $error("sync request driven while powered down");
  sync_follow_a: assert property ($rose(syncReqIn1) && secondLinkSyncRequestOe |->
    ##[1:5] (secondLinkSyncRequest || !secondLinkSyncRequestOe)) else $error("sync request lost");
  rd_unmapped_a: assert property (regRead && regAddr == 12'h000 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  rd_hold_a: assert property (!regRead && !$past(regRead) |=> $stable(regRdata))
    else $error("read data moved without a read");
endmodule : jtd_deframer_checker
bind jtd_deframer jtd_deframer_checker u_checker (
  .clk (clk), .resetn (resetn), .regWrite (regWrite), .regRead (regRead),
  .regAddr (regAddr), .regWdata (regWdata), .regRdata (regRdata), .laneIn (laneIn),
  .syncReqIn1 (syncReqIn1), .interpSel (interpSel), .samplesOut0 (samplesOut0),
  .samplesOut1 (samplesOut1), .deskewLanes (deskewLanes),
  .secondLinkSyncRequest (secondLinkSyncRequest),
  .secondLinkSyncRequestOe (secondLinkSyncRequestOe), .interpUnity (interpUnity)
);

// ### tb/test_jtd_deframer.sv
// Purpose: Self-checking bench for the transport deframer
// Assumes: Inputs change on the falling edge
// Notes:   Two-octet frames run after a fresh reset so beat pairing is known
`timescale 1ns/100ps
module test_jtd_deframer;
  logic                  clk;
  logic                  resetn;
  logic                  regWrite;
  logic                  regRead;
  logic [11:0]           regAddr;
  logic [7:0]            regWdata;
  logic [7:0]            regRdata;
  jtd_pkg::jtd_lanes_t   laneIn;
  logic                  syncReqIn1;
  logic [1:0]            interpSel;
  jtd_pkg::jtd_samples_t samplesOut0;
  jtd_pkg::jtd_samples_t samplesOut1;
  logic [7:0]            deskewLanes;
  logic                  secondLinkSyncRequest;
  logic                  secondLinkSyncRequestOe;
  logic                  interpUnity;
  int                    numErrors;
  int                    checkCount;
  int                    cycles;
  localparam logic [11:0] RST_ADDR [9] = '{12'h453, 12'h454, 12'h455, 12'h456, 12'h457,
                                           12'h458, 12'h459, 12'h45a, 12'h476};
  localparam logic [7:0]  RST_VAL  [9] = '{8'h03, 8'h00, 8'h1f, 8'h00, 8'h0f, 8'h0f,
                                           8'h21, 8'h80, 8'h01};
  jtd_deframer dut (
    .clk (clk), .resetn (resetn), .regWrite (regWrite), .regRead (regRead),
    .regAddr (regAddr), .regWdata (regWdata), .regRdata (regRdata), .laneIn (laneIn),
    .syncReqIn1 (syncReqIn1), .interpSel (interpSel), .samplesOut0 (samplesOut0),
    .samplesOut1 (samplesOut1), .deskewLanes (deskewLanes),
    .secondLinkSyncRequest (secondLinkSyncRequest),
    .secondLinkSyncRequestOe (secondLinkSyncRequestOe), .interpUnity (interpUnity)
  );
  jtd_tx_model tx (.clk (clk), .laneIn (laneIn));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      results();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic chkOut(input jtd_pkg::jtd_samples_t s, input logic v, input logic [15:0] e0);
    chk(s.valid, v);
    if (v) begin
      chk(s.s0, e0);
    end
  endtask : chkOut
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
  endtask : wr
  // Two edges before the compare, so either read latency reading is safe
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
    @(negedge clk);
    chk(regRdata, exp);
  endtask : rd
  task automatic doReset();
    @(negedge clk);
    resetn = 1'b0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
  endtask : doReset
  task automatic results();
    $display("Checks %0d, errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    {regWrite, regRead, regAddr, regWdata, syncReqIn1} = '0;
    {resetn, numErrors, checkCount, cycles} = '0;
    interpSel = 2'b01;
    doReset();
    foreach (RST_ADDR[i]) begin
      rd(RST_ADDR[i], RST_VAL[i]);
    end
    rd(12'h030, 8'h00);
    chk(interpUnity, 1'b1);
    rd(12'h000, 8'h00);
    wr(12'h030, 8'hff);
    rd(12'h030, 8'h00);
    wr(12'h46c, 8'h0f);
    wr(12'h47d, 8'h0f);
    chk(deskewLanes, 8'h0f);
    tx.beat(64'h44332211);
    tx.beat(64'h88776655);
    chkOut(samplesOut0, 1'b1, 16'h1122);
    chk(samplesOut0.s1, 16'h3344);
    chk(samplesOut1.valid, 1'b0);
    tx.idle();
    chkOut(samplesOut0, 1'b1, 16'h5566);
    wr(12'h47d, 8'h01);
    tx.beat(64'h44332211);
    tx.idle();
    chkOut(samplesOut0, 1'b1, 16'h1100);
    wr(12'h47d, 8'h0f);
    wr(12'h453, 8'h01);
    wr(12'h459, 8'h20);
    chk(interpUnity, 1'b0);
    tx.beat(64'hbbaa);
    tx.idle();
    chkOut(samplesOut0, 1'b1, 16'haabb);
    wr(12'h456, 8'h01);
    rd(12'h030, 8'h08);
    wr(12'h456, 8'h00);
    interpSel = 2'b00;
    wr(12'h455, 8'h0f);
    rd(12'h030, 8'h04);
    wr(12'h453, 8'h02);
    rd(12'h030, 8'h0c);
    tx.beat(64'hbbaa);
    tx.idle();
    chkOut(samplesOut0, 1'b0, 16'h0000);
    wr(12'h451, 8'hff);
    rd(12'h451, 8'h0f);
    wr(12'h452, 8'hff);
    rd(12'h452, 8'h1f);
    wr(12'h450, 8'h5a);
    rd(12'h450, 8'h5a);
    wr(12'h300, 8'h04);
    rd(12'h453, 8'h03);
    wr(12'h453, 8'h00);
    wr(12'h300, 8'h00);
    rd(12'h453, 8'h02);
    wr(12'h300, 8'h04);
    rd(12'h453, 8'h00);
    syncReqIn1 = 1'b1;
    repeat (5) @(negedge clk);
    chk(secondLinkSyncRequest, 1'b1);
    wr(12'h203, 8'h01);
    @(negedge clk);
    chk({secondLinkSyncRequestOe, secondLinkSyncRequest}, 2'b00);
    rd(12'h203, 8'h01);
    wr(12'h203, 8'h00);
    syncReqIn1 = 1'b0;
    repeat (5) @(negedge clk);
    chk({secondLinkSyncRequestOe, secondLinkSyncRequest}, 2'b10);
    // Fresh reset restarts the beat pairing of two-octet frames
    doReset();
    for (int p = 0; p < 2; p++) begin
      wr(12'h300, {4'h0, 1'b1, p[0], 2'b00});
      wr(12'h453, 8'h00);
      wr(12'h454, 8'h01);
      wr(12'h455, 8'h0f);
      wr(12'h459, 8'h20);
      wr(12'h45a, 8'h00);
      wr(12'h476, 8'h02);
    end
    wr(12'h47d, 8'hff);
    tx.beat(64'hc1_00000012);
    tx.beat(64'hd2_00000034);
    chkOut(samplesOut0, 1'b0, 16'h0000);
    tx.beat(64'he3_00000056);
    chkOut(samplesOut0, 1'b1, 16'h1234);
    chkOut(samplesOut1, 1'b1, 16'hc1d2);
    tx.beat(64'hf4_00000078);
    tx.idle();
    chkOut(samplesOut0, 1'b1, 16'h5678);
    chkOut(samplesOut1, 1'b1, 16'he3f4);
    rd(12'h030, 8'h00);
    wr(12'h455, 8'h04);
    rd(12'h030, 8'h04);
    tx.beat(64'hc1_00000012);
    tx.beat(64'hd2_00000034);
    tx.idle();
    chkOut(samplesOut0, 1'b0, 16'h0000);
    chkOut(samplesOut1, 1'b0, 16'h0000);
    results();
  end
endmodule : test_jtd_deframer
